// ### hw/hcf_flag_reg.sv
// Host control flag register: set/clear pair, flag effects and ack decisions
//
// Notes on behaviour
// - Image valid enables config ROM block reads
// - Image invalid: config ROM reads get type error
// - Invalid image: bus reset keeps ROM registers
// - Hardware, software reset, fetch error clear image
// - Swap disable flag controls data byte swapping
// - Late ack permit gives tardy acknowledgements
// - Each tardy ack sets event bit 27
// - Bits 28 to 24 read zero
// - Owner bit read-only, loaded, defaults one
// - Set address 50h, clear address 54h
// - Link off: no receive, process or transmit
`timescale 1ns/100ps
`include "hcf_consts.svh"
module hcf_flag_reg #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic soft_reset_i,
  input wire logic fetch_error_i,
  input wire logic link_on_control_i,
  input wire logic bus_reset_i,
  input wire logic strap_load_i,
  input wire logic strap_valid_i,
  input wire logic strap_value_i,
  input wire logic pkt_req_i,
  input wire logic pkt_rom_block_rd_i,
  input wire logic pkt_self_i,
  input wire logic pkt_busy_i,
  output hcf_pkg::hcf_ack_t pkt_ack_o,
  output logic pkt_ack_valid_o,
  output logic ack_tardy_event_o,
  output logic rom_block_rd_en_o,
  output logic rom_regs_update_o,
  output logic swap_disable_flag_o,
  output logic late_ack_permit_o,
  output logic bus_info_image_ok_o,
  output logic link_active_o
);
  import hcf_pkg::*;

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  // Flag positions are fixed, so only a full word can carry them
  if (DATA_W != 32) begin : g_bad_data_w
    $error("hcf_flag_reg needs DATA_W of 32");
  end
  // The pair's offsets are written as eight-bit constants, so eight address bits are asked for
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("hcf_flag_reg needs ADDR_W of at least 8");
  end

  // ----------------------------------------
  // Strap holder
  // ----------------------------------------
  hcf_strap_if st ();
  assign st.load = strap_load_i;
  assign st.valid = strap_valid_i;
  assign st.value = strap_value_i;
  hcf_strap_hold u_strap (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .st(st)
  );

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  logic img_q, swap_q, late_q;
  logic wr_set, wr_clr;
  logic rd_hit;

  // Offset match, shared by the write and read decoders
  function automatic logic at_ofs(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    at_ofs = (a == ADDR_W'(ofs));
  endfunction : at_ofs

  assign wr_set = reg_wr_i && at_ofs(reg_addr_i, `HCF_OFS_SET);
  assign wr_clr = reg_wr_i && at_ofs(reg_addr_i, `HCF_OFS_CLR);
  // Both addresses of the pair read back the same flags
  assign rd_hit = reg_rd_i
                  && (at_ofs(reg_addr_i, `HCF_OFS_SET) || at_ofs(reg_addr_i, `HCF_OFS_CLR));

  function automatic logic upd(input logic cur, input logic s, input logic c);
    upd = s ? 1'b1 : (c ? 1'b0 : cur);
  endfunction : upd

  // Image flag has no clear address; only hardware reset, software reset and fetch error clear it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || soft_reset_i || fetch_error_i) begin
      img_q <= 1'b0;
    end else if (wr_set && reg_wdata_i[`HCF_BIT_IMG] && !link_on_control_i) begin
      img_q <= 1'b1;
    end
  end

  // Swap control follows software only
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || soft_reset_i) begin
      swap_q <= 1'b0;
    end else begin
      swap_q <= upd(swap_q, wr_set && reg_wdata_i[`HCF_BIT_SWAP],
                    wr_clr && reg_wdata_i[`HCF_BIT_SWAP]);
    end
  end

  // Keeping the permit off while bus manager is up to software
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || soft_reset_i) begin
      late_q <= 1'b0;
    end else begin
      late_q <= upd(late_q, wr_set && reg_wdata_i[`HCF_BIT_LATE],
                    wr_clr && reg_wdata_i[`HCF_BIT_LATE]);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Reserved bits and bits kept elsewhere read as zero
  logic [DATA_W-1:0] rd_word;
  always_comb begin
    rd_word = DATA_W'(`HCF_RD_NONE);
    rd_word[`HCF_BIT_IMG] = img_q;
    rd_word[`HCF_BIT_SWAP] = swap_q;
    rd_word[`HCF_BIT_LATE] = late_q;
    rd_word[`HCF_BIT_OWN] = st.owner;
  end

  // Data stands one cycle; idle cycles return zero
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= DATA_W'(`HCF_RD_NONE);
    end else if (rd_hit) begin
      reg_rdata_o <= rd_word;
    end else begin
      reg_rdata_o <= DATA_W'(`HCF_RD_NONE);
    end
  end

  // ----------------------------------------
  // Flag outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      swap_disable_flag_o <= 1'b0;
      late_ack_permit_o <= 1'b0;
      bus_info_image_ok_o <= 1'b0;
    end else begin
      swap_disable_flag_o <= swap_q;
      late_ack_permit_o <= late_q;
      bus_info_image_ok_o <= img_q;
    end
  end

  // Mapping and header registers keep their value unless the image is valid
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rom_block_rd_en_o <= 1'b0;
      rom_regs_update_o <= 1'b0;
    end else begin
      rom_block_rd_en_o <= img_q;
      rom_regs_update_o <= bus_reset_i && img_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      link_active_o <= 1'b0;
    end else begin
      link_active_o <= link_on_control_i;
    end
  end

  // ----------------------------------------
  // Acknowledge decision
  // ----------------------------------------
  // Tardy applies to non-self packets unless a type error takes precedence, to self accesses only when busy
  hcf_ack_t ack_d;
  logic tardy_d;
  always_comb begin
    ack_d = HCF_ACK_COMPLETE;
    if (pkt_rom_block_rd_i && !img_q) begin
      ack_d = HCF_ACK_TYPE_ERR;
    end else if (late_q && (!pkt_self_i || pkt_busy_i)) begin
      ack_d = HCF_ACK_TARDY;
    end
  end
  assign tardy_d = pkt_req_i && link_on_control_i && (ack_d == HCF_ACK_TARDY);

  // Code is only meaningful while the valid pulse stands
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || soft_reset_i) begin
      pkt_ack_o <= HCF_ACK_COMPLETE;
    end else begin
      pkt_ack_o <= ack_d;
    end
  end

  // Disconnected link gives no acknowledge at all
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || soft_reset_i) begin
      pkt_ack_valid_o <= 1'b0;
    end else begin
      pkt_ack_valid_o <= pkt_req_i && link_on_control_i;
    end
  end

  // Event bit itself lives in the interrupt block
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || soft_reset_i) begin
      ack_tardy_event_o <= 1'b0;
    end else begin
      ack_tardy_event_o <= tardy_d;
    end
  end
endmodule : hcf_flag_reg

// ### shared/hcf_consts.svh
// Offsets, bit positions and reset values of the host control flag register
`ifndef HCF_CONSTS_SVH
`define HCF_CONSTS_SVH
`define HCF_OFS_SET 8'h50
`define HCF_OFS_CLR 8'h54
`define HCF_BIT_IMG 31
`define HCF_BIT_SWAP 30
`define HCF_BIT_LATE 29
`define HCF_BIT_OWN 23
`define HCF_BIT_LINK 17
`define HCF_OWN_DEFAULT 1'b1
`define HCF_RD_NONE 32'h0000_0000
`endif

// ### shared/hcf_pkg.sv
// Types shared by the host control flag register block
package hcf_pkg;
  typedef enum logic [2:0] {
    HCF_ACK_COMPLETE = 3'b001,
    HCF_ACK_TARDY = 3'b010,
    HCF_ACK_TYPE_ERR = 3'b100
  } hcf_ack_t;
  typedef enum logic [2:0] {
    HCF_ST_IDLE = 3'b001,
    HCF_ST_LOAD = 3'b010,
    HCF_ST_RUN = 3'b100
  } hcf_state_t;
endpackage : hcf_pkg

// ### shared/hcf_strap_if.sv
// Carrier of the strap load between the top and the strap holder
`timescale 1ns/100ps
interface hcf_strap_if;
  logic load;
  logic valid;
  logic value;
  logic owner;
  modport top (output load, output valid, output value, input owner);
  modport hold (input load, input valid, input value, output owner);
endinterface : hcf_strap_if

// ### hw/hcf_strap_hold.sv
// Holder of the strap-loaded owner bit
`timescale 1ns/100ps
`include "hcf_consts.svh"
module hcf_strap_hold (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  hcf_strap_if.hold st
);
  // Defaults high until a loaded value arrives
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st.owner <= `HCF_OWN_DEFAULT;
    end else if (st.load && st.valid) begin
      st.owner <= st.value;
    end
  end
endmodule : hcf_strap_hold

// ### test/hcf_flag_reg_assertions.sv
// Port checker of the host control flag register
`timescale 1ns/100ps
module hcf_flag_reg_assertions (
  input logic sys_clk_i,
  input logic rst_i,
  input logic [31:0] reg_rdata_o,
  input logic soft_reset_i,
  input logic fetch_error_i,
  input logic link_on_control_i,
  input logic bus_reset_i,
  input logic pkt_req_i,
  input logic pkt_rom_block_rd_i,
  input logic pkt_self_i,
  input logic late_ack_permit_o,
  input hcf_pkg::hcf_ack_t pkt_ack_o,
  input logic pkt_ack_valid_o,
  input logic ack_tardy_event_o,
  input logic rom_block_rd_en_o,
  input logic rom_regs_update_o,
  input logic bus_info_image_ok_o
);
  import hcf_pkg::*;
  // --------
  // Properties
  // --------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire go = pkt_req_i && link_on_control_i && !soft_reset_i;
  property p_rom; go && pkt_rom_block_rd_i |=>
    !rom_block_rd_en_o || (pkt_ack_valid_o && pkt_ack_o != HCF_ACK_TYPE_ERR); endproperty
  a_rom: assert property (p_rom) else $error("rom gate");
  property p_terr; go && pkt_rom_block_rd_i |=>
    bus_info_image_ok_o || (pkt_ack_valid_o && pkt_ack_o == HCF_ACK_TYPE_ERR); endproperty
  a_terr: assert property (p_terr) else $error("type error");
  property p_upd; bus_reset_i && !soft_reset_i |=>
    rom_regs_update_o == bus_info_image_ok_o; endproperty
  a_upd: assert property (p_upd) else $error("rom update");
  property p_lock; $rose(bus_info_image_ok_o) |-> !$past(link_on_control_i, 2); endproperty
  a_lock: assert property (p_lock) else $error("image lock");
  property p_clr; soft_reset_i || fetch_error_i |-> ##2 !bus_info_image_ok_o; endproperty
  a_clr: assert property (p_clr) else $error("image clear");
  property p_evt; go && !pkt_rom_block_rd_i && !pkt_self_i |=>
    ack_tardy_event_o == late_ack_permit_o; endproperty
  a_evt: assert property (p_evt) else $error("tardy event");
  property p_rsv; reg_rdata_o[28:24] == 5'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_off; pkt_req_i && !link_on_control_i |=> !pkt_ack_valid_o; endproperty
  a_off: assert property (p_off) else $error("link off");
  c_tardy: cover property (ack_tardy_event_o);
  c_terr: cover property (pkt_ack_valid_o && pkt_ack_o == HCF_ACK_TYPE_ERR);
  c_upd: cover property (rom_regs_update_o);
endmodule : hcf_flag_reg_assertions
bind hcf_flag_reg hcf_flag_reg_assertions u_chk (.*);

// ### test/hcf_node_model.sv
// Remote node model issuing asynchronous packets
`timescale 1ns/100ps
module hcf_node_model (
  input logic sys_clk_i,
  output logic pkt_req_i = 1'h0,
  output logic pkt_rom_block_rd_i = 1'h0,
  output logic pkt_self_i = 1'h0,
  output logic pkt_busy_i = 1'h0
);
  // Qualifiers flip after the request so stale values never help
  task send(input logic r, input logic s, input logic b);
    @(posedge sys_clk_i);
    pkt_req_i <= 1'h1;
    pkt_rom_block_rd_i <= r;
    pkt_self_i <= s;
    pkt_busy_i <= b;
    @(posedge sys_clk_i);
    pkt_req_i <= 1'h0;
    pkt_rom_block_rd_i <= ~r;
    pkt_self_i <= ~s;
    pkt_busy_i <= ~b;
  endtask : send
endmodule : hcf_node_model

// ### test/testbench.sv
// Self-checking bench of the host control flag register
`timescale 1ns/100ps
module testbench;
  import hcf_pkg::*;
  logic sys_clk_i = 1'h0, rst_i = 1'h1, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
  logic soft_reset_i = 1'h0, fetch_error_i = 1'h0, link_on_control_i = 1'h0;
  logic bus_reset_i = 1'h0, strap_load_i = 1'h0, strap_valid_i = 1'h1, strap_value_i = 1'h0;
  logic [7:0] reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic pkt_req_i, pkt_rom_block_rd_i, pkt_self_i, pkt_busy_i, pkt_ack_valid_o;
  logic ack_tardy_event_o, rom_block_rd_en_o, rom_regs_update_o, swap_disable_flag_o;
  logic late_ack_permit_o, bus_info_image_ok_o, link_active_o;
  hcf_ack_t pkt_ack_o;
  wire [4:0] fl = {bus_info_image_ok_o, swap_disable_flag_o, late_ack_permit_o,
    rom_block_rd_en_o, link_active_o};
  int n_errors = 0;
  int n_checks = 0;
  hcf_node_model node (.*);
  hcf_flag_reg uut (.*);
  initial forever #4 sys_clk_i = ~sys_clk_i;
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task wrt(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'h0;
  endtask : wrt
  task rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'h0;
    #1 chk("rdata", e, reg_rdata_o);
  endtask : rdc
  // Expected is valid, event, ack code
  task pk(input logic r, input logic s, input logic b, input logic [4:0] e);
    node.send(r, s, b);
    #1 chk("ack", {27'h0, e}, {27'h0, pkt_ack_valid_o, ack_tardy_event_o,
      pkt_ack_valid_o ? pkt_ack_o : 3'h0});
  endtask : pk
  // Pulses bus reset, fetch error, soft reset, strap load
  task hit(input logic [3:0] m);
    @(posedge sys_clk_i);
    {bus_reset_i, fetch_error_i, soft_reset_i, strap_load_i} <= m;
    @(posedge sys_clk_i);
    {bus_reset_i, fetch_error_i, soft_reset_i, strap_load_i} <= 4'h0;
    #1;
  endtask : hit
  task summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (2000) @(posedge sys_clk_i);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    rdc(8'h50, 32'h0080_0000);
    wrt(8'h50, 32'hdf80_0000);
    rdc(8'h54, 32'hc080_0000);
    chk("flags", 32'h1a, {27'h0, fl});
    wrt(8'h54, 32'hc000_0000);
    rdc(8'h50, 32'h8080_0000);
    chk("flags", 32'h12, {27'h0, fl});
    $display("test set_clear done");
    @(posedge sys_clk_i) link_on_control_i <= 1'h1;
    pk(1'h1, 1'h0, 1'h0, 5'h11);
    hit(4'h8);
    chk("update", 32'h1, {31'h0, rom_regs_update_o});
    hit(4'h4);
    pk(1'h1, 1'h0, 1'h0, 5'h14);
    hit(4'h8);
    chk("update", 32'h0, {31'h0, rom_regs_update_o});
    wrt(8'h50, 32'h8000_0000);
    wrt(8'h50, 32'h2000_0000);
    rdc(8'h50, 32'h2080_0000);
    chk("flags", 32'h05, {27'h0, fl});
    pk(1'h0, 1'h0, 1'h0, 5'h1a);
    pk(1'h0, 1'h1, 1'h0, 5'h11);
    pk(1'h0, 1'h1, 1'h1, 5'h1a);
    pk(1'h1, 1'h0, 1'h0, 5'h14);
    wrt(8'h54, 32'h2000_0000);
    pk(1'h0, 1'h0, 1'h0, 5'h11);
    $display("test packets done");
    @(posedge sys_clk_i) link_on_control_i <= 1'h0;
    pk(1'h0, 1'h0, 1'h0, 5'h0);
    rdc(8'h40, 32'h0);
    wrt(8'h50, 32'h8000_0000);
    rdc(8'h50, 32'h8080_0000);
    hit(4'h2);
    rdc(8'h50, 32'h0080_0000);
    hit(4'h1);
    rdc(8'h50, 32'h0);
    $display("test shutdown done");
    summarize();
  end
endmodule : testbench
